// ---- inc/dbd_pkg.sv ----
// constants, field layout and carrier types of the disk buffer dma control
// assumes one 20 MHz clock domain and an 8-bit multiplexed processor port
package dbd_pkg;

	// register offsets on the processor port
	localparam logic [7:0] OFS_START_STOP = 8'hba;
	localparam logic [7:0] OFS_CAP_HIGH = 8'hbc;
	localparam logic [7:0] OFS_CAP_LOW = 8'hbe;
	localparam logic [7:0] OFS_STATUS = 8'hc0;
	localparam logic [7:0] OFS_PTR_HIGH = 8'hc2;
	localparam logic [7:0] OFS_PTR_MID = 8'hc4;
	localparam logic [7:0] OFS_PTR_LOW = 8'hc6;
	localparam logic [7:0] OFS_AUTO_ODD = 8'hc8;
	localparam logic [7:0] OFS_AUTO_EVEN = 8'hca;
	localparam logic [7:0] OFS_LATCH_ODD = 8'hcc;
	localparam logic [7:0] OFS_LATCH_EVEN = 8'hce;

	// start/stop control bits
	localparam int unsigned SS_GO = 0;
	localparam int unsigned SS_ABORT = 1;
	localparam int unsigned SS_DIAG = 2;

	// status bits
	localparam int unsigned ST_HOST_BUSY = 0;
	localparam int unsigned ST_HOST_VBUSY = 1;
	localparam int unsigned ST_DISK_BUSY = 2;
	localparam int unsigned ST_DISK_VBUSY = 3;
	localparam int unsigned ST_CPU_PERR = 4;
	localparam int unsigned ST_DISK_PERR = 5;
	localparam int unsigned ST_HOST_PERR = 6;

	// capture high byte: flag in bit 7, count bits 14:8 below it
	localparam int unsigned CAP_FLAG_BIT = 7;

	// widths
	localparam int unsigned PTR_W = 23;
	localparam int unsigned CNT_W = 15;
	localparam int unsigned SEG_W = 5;
	localparam int unsigned BLK_W = 8;

	// reset values and pointer step
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [PTR_W-1:0] RST_PTR = 23'h000000;
	localparam logic [CNT_W-1:0] RST_CNT = 15'h0000;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [PTR_W-1:0] PTR_STEP = 23'h000001;

	typedef enum logic [1:0] {
		DBD_IDLE,
		DBD_BUSY,
		DBD_VBUSY
	} dbd_pipe_t;

	typedef enum logic {
		DBD_BUF_IDLE,
		DBD_BUF_WAIT
	} dbd_buf_st_t;

	// processor port pins after the synchroniser
	typedef struct packed {
		logic ale;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [7:0] ad;
	} dbd_cpu_pins_t;

	// processor request toward buffer memory
	typedef struct packed {
		logic req;
		logic we;
		logic [PTR_W-1:0] addr;
		logic [15:0] wdata;
	} dbd_buf_req_t;

	// disk dma launch toward the transfer engine
	typedef struct packed {
		logic go;
		logic [PTR_W-1:0] abs_addr;
		logic [BLK_W-1:0] count;
	} dbd_disk_cmd_t;

endpackage : dbd_pkg

// ---- logic/dbd_sync.sv ----
// two flip-flop synchroniser for a bundle of pin levels
// assumes each bit is a level that stays for several clocks
`timescale 1ns/1ps
module dbd_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	// the first stage feeds only the second
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_r <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule : dbd_sync

// ---- logic/dbd_dma_ctl.sv ----
// disk buffer dma control: start/stop, count capture, status, cpu buffer path
// assumes an 8-bit multiplexed processor port on pins and buffer memory,
// disk engine and ecc corrector as on-chip logic on ref_clk_i
`timescale 1ns/1ps
// How it works
// - diag load bit set: relative address moves into the address counter
// - abort bit set: disk dma stops, pipeline returns to idle
// - start bit launches dma with absolute address and transfer count
// - each start steps pipeline up once: idle to busy, busy to very busy
// - adjust flag zero unless very busy fell to busy with ecc pending
// - adjust flag drops on ecc success or disk soft reset
// - 15-bit count capture holds value from last capture request
// - host parity bit set on parity error during host buffer read
// - disk parity bit set on parity error in disk read or ecc cycle
// - cpu parity bit set on parity error during processor buffer read
// - status shows live disk and host busy and very busy states
// - even autoincrement port access advances the buffer pointer
// - data latch port access leaves the pointer unchanged
// - capture request latches adjust flag, block and buffer counts
module dbd_dma_ctl
	import dbd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// processor port pins
	input wire logic cpu_ale_i,
	input wire logic cpu_cs_n_i,
	input wire logic cpu_rd_n_i,
	input wire logic cpu_wr_n_i,
	input wire logic [7:0] cpu_ad_i,
	output logic [7:0] cpu_ad_o,
	output logic cpu_ad_oe_o,
	output logic cpu_wait_o,
	// disk pipeline variables and events
	input wire logic [dbd_pkg::SEG_W-1:0] disk_seg_i,
	input wire logic [dbd_pkg::PTR_W-1:0] seg_size_i,
	input wire logic [dbd_pkg::PTR_W-1:0] rel_addr_i,
	input wire logic [dbd_pkg::BLK_W-1:0] block_count_i,
	input wire logic disk_xfer_done_i,
	input wire logic disk_soft_reset_i,
	input wire logic ecc_pending_i,
	input wire logic ecc_ok_i,
	input wire logic disk_capture_request_i,
	input wire logic [dbd_pkg::CNT_W-1:0] disk_buff_count_i,
	// disk dma launch and counter diagnostic
	output dbd_pkg::dbd_disk_cmd_t disk_cmd_o,
	output logic disk_abort_o,
	output logic counter_diag_load_o,
	output logic [dbd_pkg::PTR_W-1:0] diag_addr_o,
	output logic [dbd_pkg::BLK_W-1:0] block_capture_o,
	// host pipeline state and parity sources
	input wire logic host_pipe_busy_i,
	input wire logic host_pipe_very_busy_i,
	input wire logic host_buffer_parity_error_i,
	input wire logic disk_buffer_parity_error_i,
	// buffer memory port for processor accesses
	output dbd_pkg::dbd_buf_req_t buf_req_o,
	input wire logic buf_ack_i,
	input wire logic [15:0] buf_rdata_i,
	input wire logic buf_par_err_i
);
	import dbd_pkg::*;
	// absolute address = segment * segment size + relative address
	function automatic logic [PTR_W-1:0] abs_addr_f(
		input logic [SEG_W-1:0] seg,
		input logic [PTR_W-1:0] size,
		input logic [PTR_W-1:0] rel
	);
		logic [PTR_W+SEG_W-1:0] prod;
		prod = seg * size;
		return PTR_W'(prod[PTR_W-1:0] + rel);
	endfunction : abs_addr_f
	function automatic logic is_even_port(input logic [7:0] a);
		return (a == OFS_AUTO_EVEN) || (a == OFS_LATCH_EVEN);
	endfunction : is_even_port
	// synchronised pins
	dbd_cpu_pins_t pins;
	logic ale_d_r;
	logic rd_n_d_r;
	logic wr_n_d_r;
	dbd_sync #(
		.W($bits(dbd_cpu_pins_t)),
		.RST_VAL({1'b0, 1'b1, 1'b1, 1'b1, RST_BYTE})
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.d_i({cpu_ale_i, cpu_cs_n_i, cpu_rd_n_i, cpu_wr_n_i, cpu_ad_i}),
		.q_o(pins)
	);

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ale_d_r <= 1'b0;
			rd_n_d_r <= 1'b1;
			wr_n_d_r <= 1'b1;
		end else begin
			ale_d_r <= pins.ale;
			rd_n_d_r <= pins.rd_n;
			wr_n_d_r <= pins.wr_n;
		end
	end
	// address taken as ale falls; strobes count only with select low
	logic [7:0] addr_r;
	logic wr_ev;
	logic rd_ev;
	logic rd_end;
	assign wr_ev = pins.wr_n & ~wr_n_d_r & ~pins.cs_n;
	assign rd_ev = ~pins.rd_n & rd_n_d_r & ~pins.cs_n;
	assign rd_end = pins.rd_n & ~rd_n_d_r;
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			addr_r <= RST_BYTE;
		end else if (ale_d_r && !pins.ale) begin
			addr_r <= pins.ad;
		end
	end
	// start/stop control register
	logic [7:0] ss_r;
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ss_r <= RST_BYTE;
		end else if (wr_ev && addr_r == OFS_START_STOP) begin
			ss_r <= pins.ad;
		end else begin
			// go is a request, so it acts once per write
			ss_r[SS_GO] <= 1'b0;
		end
	end
	// disk pipeline
	dbd_pipe_t pipe_r;
	dbd_pipe_t pipe_nxt;
	logic go_ok;
	// a start written while abort is set is dropped
	assign go_ok = ss_r[SS_GO] & ~ss_r[SS_ABORT];
	always_comb begin
		pipe_nxt = pipe_r;
		if (ss_r[SS_ABORT]) begin
			pipe_nxt = DBD_IDLE;
		end else if (go_ok && !disk_xfer_done_i) begin
			unique case (pipe_r)
				DBD_IDLE: pipe_nxt = DBD_BUSY;
				DBD_BUSY: pipe_nxt = DBD_VBUSY;
				DBD_VBUSY: pipe_nxt = DBD_VBUSY;
				default: pipe_nxt = DBD_IDLE;
			endcase
		end else if (disk_xfer_done_i && !go_ok) begin
			unique case (pipe_r)
				DBD_VBUSY: pipe_nxt = DBD_BUSY;
				DBD_BUSY: pipe_nxt = DBD_IDLE;
				DBD_IDLE: pipe_nxt = DBD_IDLE;
				default: pipe_nxt = DBD_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pipe_r <= DBD_IDLE;
		end else begin
			pipe_r <= pipe_nxt;
		end
	end
	// launch toward the disk engine; a start in very busy is not queued
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			disk_cmd_o <= '0;
			disk_abort_o <= 1'b0;
		end else begin
			disk_abort_o <= ss_r[SS_ABORT];
			disk_cmd_o.go <= go_ok && pipe_r != DBD_VBUSY;
			if (go_ok) begin
				disk_cmd_o.abs_addr <= abs_addr_f(disk_seg_i, seg_size_i,
					rel_addr_i);
				disk_cmd_o.count <= block_count_i;
			end
		end
	end
	// counter diagnostic load follows the bit as a level
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			counter_diag_load_o <= 1'b0;
			diag_addr_o <= RST_PTR;
		end else begin
			counter_diag_load_o <= ss_r[SS_DIAG];
			if (ss_r[SS_DIAG]) begin
				diag_addr_o <= rel_addr_i;
			end
		end
	end
	// pending adjust flag; the setting event wins over ecc success
	logic adjust_r;
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			adjust_r <= 1'b0;
		end else if (disk_soft_reset_i) begin
			adjust_r <= 1'b0;
		end else if (pipe_r == DBD_VBUSY && pipe_nxt == DBD_BUSY &&
			ecc_pending_i) begin
			adjust_r <= 1'b1;
		end else if (ecc_ok_i) begin
			adjust_r <= 1'b0;
		end
	end
	// capture registers
	logic cap_flag_r;
	logic [CNT_W-1:0] cap_cnt_r;
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cap_flag_r <= 1'b0;
			cap_cnt_r <= RST_CNT;
			block_capture_o <= RST_BYTE;
		end else if (disk_capture_request_i) begin
			cap_flag_r <= adjust_r;
			cap_cnt_r <= disk_buff_count_i;
			block_capture_o <= block_count_i;
		end
	end
	// sticky parity flags, cleared by disk soft reset; a new error wins
	logic host_perr_r;
	logic disk_perr_r;
	logic cpu_perr_r;
	logic cpu_rd_busy;

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			host_perr_r <= 1'b0;
		end else if (host_buffer_parity_error_i) begin
			host_perr_r <= 1'b1;
		end else if (disk_soft_reset_i) begin
			host_perr_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			disk_perr_r <= 1'b0;
		end else if (disk_buffer_parity_error_i) begin
			disk_perr_r <= 1'b1;
		end else if (disk_soft_reset_i) begin
			disk_perr_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cpu_perr_r <= 1'b0;
		end else if (cpu_rd_busy && buf_ack_i && buf_par_err_i) begin
			cpu_perr_r <= 1'b1;
		end else if (disk_soft_reset_i) begin
			cpu_perr_r <= 1'b0;
		end
	end
	// processor buffer path: odd byte is held, even byte moves the word
	dbd_buf_st_t bst_r;
	logic [PTR_W-1:0] ptr_r;
	logic [7:0] odd_hold_r;
	logic auto_r;
	logic start_wr;
	logic start_rd;
	assign start_wr = wr_ev && is_even_port(addr_r) && bst_r == DBD_BUF_IDLE;
	assign start_rd = rd_ev && is_even_port(addr_r) && bst_r == DBD_BUF_IDLE;
	assign cpu_rd_busy = bst_r == DBD_BUF_WAIT && !buf_req_o.we;

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			bst_r <= DBD_BUF_IDLE;
			buf_req_o <= '0;
			auto_r <= 1'b0;
		end else begin
			unique case (bst_r)
				DBD_BUF_IDLE: begin
					if (start_wr || start_rd) begin
						bst_r <= DBD_BUF_WAIT;
						buf_req_o.req <= 1'b1;
						buf_req_o.we <= start_wr;
						buf_req_o.addr <= ptr_r;
						buf_req_o.wdata <= {odd_hold_r, pins.ad};
						auto_r <= addr_r == OFS_AUTO_EVEN;
					end
				end
				DBD_BUF_WAIT: begin
					if (buf_ack_i) begin
						bst_r <= DBD_BUF_IDLE;
						buf_req_o.req <= 1'b0;
					end
				end
			endcase
		end
	end
	// pointer: loaded by byte writes, stepped after even autoincrement accesses
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ptr_r <= RST_PTR;
		end else if (bst_r == DBD_BUF_WAIT && buf_ack_i) begin
			if (auto_r) begin
				ptr_r <= ptr_r + PTR_STEP;
			end
		end else if (wr_ev) begin
			unique case (addr_r)
				OFS_PTR_HIGH: ptr_r[PTR_W-1:16] <= pins.ad[PTR_W-17:0];
				OFS_PTR_MID: ptr_r[15:8] <= pins.ad;
				OFS_PTR_LOW: ptr_r[7:0] <= pins.ad;
				default: ptr_r <= ptr_r;
			endcase
		end
	end
	// odd byte: written by the processor or taken from a word read
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			odd_hold_r <= RST_BYTE;
		end else if (cpu_rd_busy && buf_ack_i) begin
			odd_hold_r <= buf_rdata_i[15:8];
		end else if (wr_ev && (addr_r == OFS_AUTO_ODD ||
			addr_r == OFS_LATCH_ODD)) begin
			odd_hold_r <= pins.ad;
		end
	end
	// read data register
	logic [7:0] rd_data_r;
	logic [7:0] status;
	logic rd_active_r;
	assign status = {1'b0, host_perr_r, disk_perr_r, cpu_perr_r,
		pipe_r == DBD_VBUSY, pipe_r == DBD_BUSY,
		host_pipe_very_busy_i, host_pipe_busy_i};

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_data_r <= RST_BYTE;
		end else if (cpu_rd_busy && buf_ack_i) begin
			rd_data_r <= buf_rdata_i[7:0];
		end else if (rd_ev) begin
			unique case (addr_r)
				OFS_CAP_HIGH: rd_data_r <= {cap_flag_r, cap_cnt_r[CNT_W-1:8]};
				OFS_CAP_LOW: rd_data_r <= cap_cnt_r[7:0];
				OFS_STATUS: rd_data_r <= status;
				OFS_PTR_HIGH: rd_data_r <= {1'b0, ptr_r[PTR_W-1:16]};
				OFS_PTR_MID: rd_data_r <= ptr_r[15:8];
				OFS_PTR_LOW: rd_data_r <= ptr_r[7:0];
				OFS_AUTO_ODD: rd_data_r <= odd_hold_r;
				OFS_LATCH_ODD: rd_data_r <= odd_hold_r;
				default: rd_data_r <= RST_BYTE;
			endcase
		end
	end
	// drive the bus from the read strobe until it rises again
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_active_r <= 1'b0;
		end else if (rd_ev) begin
			rd_active_r <= 1'b1;
		end else if (rd_end) begin
			rd_active_r <= 1'b0;
		end
	end
	// the strobe must be stretched while a buffer word is in flight
	assign cpu_wait_o = bst_r == DBD_BUF_WAIT || start_rd || start_wr;
	assign cpu_ad_o = rd_data_r;
	assign cpu_ad_oe_o = rd_active_r && !pins.rd_n;

endmodule : dbd_dma_ctl

// ---- sim/dbd_dma_ctl_sva.sv ----
// assertions on the disk buffer dma control ports
// assumes one clock domain and steady pipeline inputs around a start
`timescale 1ns/1ps
module dbd_dma_ctl_sva
	import dbd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// watched ports
	input wire logic cpu_rd_n_i,
	input wire logic cpu_ad_oe_o,
	input wire logic [dbd_pkg::SEG_W-1:0] disk_seg_i,
	input wire logic [dbd_pkg::PTR_W-1:0] seg_size_i,
	input wire logic [dbd_pkg::PTR_W-1:0] rel_addr_i,
	input wire logic [dbd_pkg::BLK_W-1:0] block_count_i,
	input wire logic disk_capture_request_i,
	input wire dbd_pkg::dbd_disk_cmd_t disk_cmd_o,
	input wire logic disk_abort_o,
	input wire logic counter_diag_load_o,
	input wire logic [dbd_pkg::PTR_W-1:0] diag_addr_o,
	input wire logic [dbd_pkg::BLK_W-1:0] block_capture_o,
	input wire dbd_pkg::dbd_buf_req_t buf_req_o,
	input wire logic buf_ack_i
);
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);
	// four high samples let the strobe through both sync flops
	sequence s_rd_idle;
		cpu_rd_n_i [*4];
	endsequence
	sequence s_req_open;
		buf_req_o.req && !buf_ack_i;
	endsequence
	a_go_pulse: assert property (disk_cmd_o.go |=> !disk_cmd_o.go)
		else $error("go longer than one cycle");
	a_go_addr: assert property (disk_cmd_o.go |->
		disk_cmd_o.abs_addr == disk_seg_i * seg_size_i + rel_addr_i
		&& disk_cmd_o.count == block_count_i)
		else $error("launch address or count wrong");
	a_abort_idle: assert property (disk_abort_o |-> !disk_cmd_o.go)
		else $error("launch while aborted");
	a_diag_addr: assert property (
		counter_diag_load_o && $past(counter_diag_load_o)
		|-> diag_addr_o == $past(rel_addr_i))
		else $error("diag address not loaded");
	a_cap_latch: assert property (
		disk_capture_request_i |=> block_capture_o == $past(block_count_i))
		else $error("block count not captured");
	a_cap_hold: assert property (
		!disk_capture_request_i |=> $stable(block_capture_o))
		else $error("capture changed without request");
	a_req_hold: assert property (
		s_req_open |=> buf_req_o.req && $stable(buf_req_o.addr))
		else $error("buffer request dropped early");
	a_ack_drop: assert property (buf_ack_i |=> !buf_req_o.req)
		else $error("request held after ack");
	a_oe_release: assert property (s_rd_idle |-> !cpu_ad_oe_o)
		else $error("bus driven after read");
endmodule : dbd_dma_ctl_sva

// ---- sim/dbd_buf_mem.sv ----
// buffer memory model answering processor word requests
// assumes one request at a time, held until acknowledged
`timescale 1ns/1ps
module dbd_buf_mem
	import dbd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// request side
	input wire dbd_pkg::dbd_buf_req_t req_i,
	input wire logic [2:0] lat_i,
	input wire logic perr_i,
	// answer side
	output logic ack_o,
	output logic [15:0] rdata_o,
	output logic perr_o
);
	// only the low address byte is kept; enough for short tests
	logic [15:0] mem_r [0:255];
	logic [2:0] cnt_r;
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r <= 3'h0;
			ack_o <= 1'b0;
			perr_o <= 1'b0;
			rdata_o <= 16'h0000;
		end else begin
			ack_o <= 1'b0;
			perr_o <= 1'b0;
			// stale data is inverted each cycle, so it shows the last word read again on every second cycle
			rdata_o <= ~rdata_o;
			if (req_i.req && !ack_o) begin
				if (cnt_r == lat_i) begin
					cnt_r <= 3'h0;
					ack_o <= 1'b1;
					perr_o <= perr_i && !req_i.we;
					if (req_i.we)
						mem_r[req_i.addr[7:0]] <= req_i.wdata;
					else
						rdata_o <= mem_r[req_i.addr[7:0]];
				end else begin
					cnt_r <= cnt_r + 3'h1;
				end
			end
		end
	end
endmodule : dbd_buf_mem

// ---- sim/testbench.sv ----
// self-checking bench for the disk buffer dma control
// assumes the buffer memory model stands on the buffer port
`timescale 1ns/1ps
module testbench;
	import dbd_pkg::*;
	localparam logic [4:0] SEG = 5'h03;
	localparam logic [22:0] SIZE = 23'h001000;
	localparam logic [22:0] REL = 23'h000123;
	localparam logic [7:0] BLK = 8'h21;
	logic ref_clk_i = 0, reset_i = 1;
	logic cpu_ale_i = 0, cpu_cs_n_i = 1, cpu_rd_n_i = 1, cpu_wr_n_i = 1;
	logic [7:0] ad_drv = 8'h00;
	logic [7:0] cpu_ad_o;
	wire [7:0] cpu_ad_i;
	logic cpu_ad_oe_o, cpu_wait_o, disk_abort_o, counter_diag_load_o;
	logic [4:0] disk_seg_i = SEG;
	logic [22:0] seg_size_i = SIZE, rel_addr_i = REL, diag_addr_o;
	logic [22:0] last_abs = 23'h000000;
	logic [7:0] block_count_i = BLK, block_capture_o;
	logic disk_xfer_done_i = 0, disk_soft_reset_i = 0, ecc_pending_i = 0;
	logic ecc_ok_i = 0, disk_capture_request_i = 0;
	logic [14:0] disk_buff_count_i = 15'h5a3c;
	logic host_pipe_busy_i = 0, host_pipe_very_busy_i = 0;
	logic host_buffer_parity_error_i = 0, disk_buffer_parity_error_i = 0;
	logic buf_ack_i, buf_par_err_i, perr_inj = 0;
	logic [15:0] buf_rdata_i;
	logic [2:0] lat = 3'h0;
	dbd_disk_cmd_t disk_cmd_o;
	dbd_buf_req_t buf_req_o;
	int n_mismatch = 0, check_count = 0, n_go = 0, cycles = 0;
	// the bus resolves to the device whenever it drives
	assign cpu_ad_i = cpu_ad_oe_o ? cpu_ad_o : ad_drv;
	dbd_dma_ctl dut (.*);
	dbd_buf_mem u_mem (.ref_clk_i, .reset_i, .req_i(buf_req_o), .lat_i(lat),
		.perr_i(perr_inj), .ack_o(buf_ack_i), .rdata_o(buf_rdata_i),
		.perr_o(buf_par_err_i));
	always #25 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cycles++;
		if (disk_cmd_o.go === 1'b1) begin
			n_go++;
			last_abs = disk_cmd_o.abs_addr;
		end
		if (cycles == 6000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#5;
	endtask : cyc
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask : pulse
	// strobes are held while a buffer word is in flight;
	// a wait that never drops runs into the cycle ceiling
	task automatic idle;
		while (cpu_wait_o !== 1'b0) begin
			cyc(1);
		end
	endtask : idle
	task automatic adr(input logic [7:0] a);
		idle();
		ad_drv = a;
		cpu_ale_i = 1;
		cyc(3);
		cpu_ale_i = 0;
		cyc(3);
	endtask : adr
	// select is dropped after the strobe so the sync sees it low
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		adr(a);
		ad_drv = d;
		cpu_cs_n_i = 0;
		cpu_wr_n_i = 0;
		cyc(3);
		idle();
		cpu_wr_n_i = 1;
		cyc(3);
		cpu_cs_n_i = 1;
		cyc(1);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		adr(a);
		ad_drv = ~a;
		cpu_cs_n_i = 0;
		cpu_rd_n_i = 0;
		cyc(4);
		idle();
		cyc(2);
		chk(cpu_ad_o, e);
		chk(cpu_ad_oe_o, 1'b1);
		cpu_rd_n_i = 1;
		cyc(3);
		cpu_cs_n_i = 1;
		cyc(1);
	endtask : rdc
	task automatic t_regs;
		wr(OFS_STATUS, 8'hff);
		rdc(OFS_STATUS, 8'h00);
		rdc(OFS_START_STOP, 8'h00);
		rdc(8'hd0, 8'h00);
		wr(OFS_PTR_HIGH, 8'hff);
		rdc(OFS_PTR_HIGH, 8'h7f);
		host_pipe_busy_i = 1;
		rdc(OFS_STATUS, 8'h01);
		host_pipe_busy_i = 0;
		host_pipe_very_busy_i = 1;
		rdc(OFS_STATUS, 8'h02);
		host_pipe_very_busy_i = 0;
	endtask : t_regs
	task automatic t_pipe;
		wr(OFS_START_STOP, 8'h01);
		rdc(OFS_STATUS, 8'h04);
		chk(last_abs, SEG * SIZE + REL);
		wr(OFS_START_STOP, 8'h01);
		wr(OFS_START_STOP, 8'h01);
		rdc(OFS_STATUS, 8'h08);
		chk(n_go, 2);
		pulse(disk_xfer_done_i);
		rdc(OFS_STATUS, 8'h04);
		wr(OFS_START_STOP, 8'h02);
		chk(disk_abort_o, 1'b1);
		rdc(OFS_STATUS, 8'h00);
		wr(OFS_START_STOP, 8'h03);
		rdc(OFS_STATUS, 8'h00);
		wr(OFS_START_STOP, 8'h00);
		chk(disk_abort_o, 1'b0);
		pulse(disk_soft_reset_i);
		wr(OFS_START_STOP, 8'h01);
		// the launch pulse is counted one edge after it appears
		cyc(2);
		chk(n_go, 3);
		pulse(disk_xfer_done_i);
		rdc(OFS_STATUS, 8'h00);
	endtask : t_pipe
	task automatic t_adj;
		ecc_pending_i = 1;
		wr(OFS_START_STOP, 8'h01);
		wr(OFS_START_STOP, 8'h01);
		pulse(disk_xfer_done_i);
		pulse(disk_capture_request_i);
		rdc(OFS_CAP_HIGH, 8'hda);
		rdc(OFS_CAP_LOW, 8'h3c);
		chk(block_capture_o, BLK);
		disk_buff_count_i = 15'h0101;
		rdc(OFS_CAP_LOW, 8'h3c);
		pulse(ecc_ok_i);
		pulse(disk_capture_request_i);
		rdc(OFS_CAP_HIGH, 8'h01);
		wr(OFS_START_STOP, 8'h01);
		pulse(disk_xfer_done_i);
		pulse(disk_soft_reset_i);
		pulse(disk_capture_request_i);
		rdc(OFS_CAP_HIGH, 8'h01);
		pulse(disk_xfer_done_i);
		pulse(disk_capture_request_i);
		rdc(OFS_CAP_HIGH, 8'h01);
		ecc_pending_i = 0;
	endtask : t_adj
	task automatic t_par;
		pulse(host_buffer_parity_error_i);
		rdc(OFS_STATUS, 8'h40);
		pulse(disk_buffer_parity_error_i);
		rdc(OFS_STATUS, 8'h60);
		pulse(disk_soft_reset_i);
		rdc(OFS_STATUS, 8'h00);
	endtask : t_par
	task automatic t_buf;
		wr(OFS_PTR_HIGH, 8'h01);
		wr(OFS_PTR_MID, 8'h23);
		wr(OFS_PTR_LOW, 8'h45);
		wr(OFS_AUTO_ODD, 8'hab);
		wr(OFS_AUTO_EVEN, 8'hcd);
		rdc(OFS_PTR_LOW, 8'h46);
		chk(u_mem.mem_r[8'h45], 16'habcd);
		lat = 3'h3;
		wr(OFS_LATCH_ODD, 8'h12);
		wr(OFS_LATCH_EVEN, 8'h34);
		chk(cpu_wait_o, 1'b1);
		rdc(OFS_PTR_LOW, 8'h46);
		rdc(OFS_LATCH_EVEN, 8'h34);
		rdc(OFS_LATCH_ODD, 8'h12);
		rdc(OFS_AUTO_EVEN, 8'h34);
		rdc(OFS_AUTO_ODD, 8'h12);
		rdc(OFS_PTR_LOW, 8'h47);
		wr(OFS_PTR_LOW, 8'h45);
		perr_inj = 1;
		rdc(OFS_LATCH_EVEN, 8'hcd);
		perr_inj = 0;
		rdc(OFS_STATUS, 8'h10);
	endtask : t_buf
	task automatic t_diag;
		wr(OFS_START_STOP, 8'h04);
		cyc(3);
		chk(counter_diag_load_o, 1'b1);
		chk(diag_addr_o, REL);
		wr(OFS_START_STOP, 8'h00);
		cyc(3);
		chk(counter_diag_load_o, 1'b0);
	endtask : t_diag
	initial begin
		cyc(4);
		reset_i = 0;
		cyc(2);
		t_regs();
		t_pipe();
		t_adj();
		t_par();
		t_buf();
		t_diag();
		end_of_test();
	end
endmodule : testbench
bind dbd_dma_ctl dbd_dma_ctl_sva u_sva (.*);
